// ===== scr_pkg.sv
`default_nettype none
package scr_pkg;
  // device register offsets
  localparam logic [14:0] ADDR_IFCFG = 15'h0000;
  localparam logic [14:0] ADDR_MODE = 15'h0002;
  localparam logic [14:0] ADDR_MAKER_LO = 15'h000C;
  localparam logic [14:0] ADDR_MAKER_HI = 15'h000D;
  localparam logic [14:0] ADDR_USER = 15'h0010;
  localparam logic [14:0] ADDR_ALIGN = 15'h0029;
  localparam logic [14:0] ADDR_POS0 = 15'h002C;
  localparam logic [14:0] ADDR_POS1 = 15'h002D;
  localparam logic [14:0] ADDR_POS2 = 15'h002E;
  // reset values
  localparam logic [7:0] IFCFG_RST = 8'h30;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] USER_RST = 8'h00;
  localparam logic [7:0] ALIGN_RST = 8'h80;
  // reserved bits and their fixed values on write
  localparam logic [7:0] IFCFG_RSV_MASK = 8'h4F;
  localparam logic [7:0] MODE_RSV_MASK = 8'hFC;
  localparam logic [7:0] USER_RSV_MASK = 8'hFE;
  localparam logic [7:0] ALIGN_RSV_MASK = 8'h80;
  // field positions
  localparam int IFCFG_RESET_BIT = 7;
  localparam int IFCFG_ASCEND_BIT = 5;
  localparam int IFCFG_SEP_OUT_BIT = 4;
  localparam int USER_HOLD_BIT = 0;
  localparam int ALIGN_PROC_BIT = 6;
  localparam int ALIGN_RECV_BIT = 5;
  localparam int ALIGN_ZOOM_BIT = 4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
  // arbitrary value, not a real maker code
  localparam logic [15:0] MAKER_CODE_DEF = 16'h5A3C;
  // framing: 1 direction bit, 15 address bits, then data bytes
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_HALF_NS = 80;
  localparam int RESET_WAIT_NS = 750;
  localparam logic [6:0] SCLK_HALF_CYC = 7'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] RESET_WAIT_CYC = 7'((RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // host apb offsets and status bits
  localparam logic [7:0] HOST_ADDR_OFS = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
  localparam logic [7:0] HOST_CMD_OFS = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0C;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
endpackage : scr_pkg
`default_nettype wire

// ===== scr_link_if.sv
`default_nettype none
interface scr_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport hst (output sclk, output cs_n, output mosi, input miso);
endinterface : scr_link_if
`default_nettype wire

// ===== scr_dev.sv
// Summary of operation
// - writing reset trigger resets all registers
// - reset trigger bit clears itself
// - host waits 750ns after reset request
// - streaming address decrements on 0, increments on 1
// - separate output flag always reads one
// - reads return only on dedicated output line
// - mode 0 normal, 3 power down
// - fixed read-only 16-bit maker code
// - address freeze holds streaming address constant
// - processor enable gates alignment events
// - receiver enabled no later than processor
// - receiver active only while enabled
// - zoom bit shrinks position and delay steps
// - four-bit delay choice selects capture delay
// - 24-bit read-only edge position report
`default_nettype none
module scr_dev #(
  parameter logic [15:0] MAKER_CODE = scr_pkg::MAKER_CODE_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  scr_link_if.dev link,
  input wire logic [23:0] align_edge_position_i,
  input wire logic align_event_i,
  output logic chip_reset_o,
  output logic device_power_down_o,
  output logic align_receiver_on_o,
  output logic align_processor_on_o,
  output logic window_fine_scale_o,
  output logic [3:0] align_delay_choice_o,
  output logic align_event_o
);

  typedef enum logic [1:0] {
    ST_HDR = 2'b01,
    ST_DATA = 2'b10
  } scr_dev_st_t;

  scr_dev_st_t st_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic csn_s1_q, csn_s2_q;
  logic sdi_s1_q, sdi_s2_q;
  logic [14:0] sh_q;
  logic [3:0] bcnt_q;
  logic rw_q;
  logic [14:0] addr_q;
  logic [14:0] addr_d;
  logic [14:0] hdr_addr;
  logic [7:0] tx_q;
  logic sdo_q;
  logic [7:0] ifcfg_q;
  logic [7:0] mode_q;
  logic [7:0] user_q;
  logic [7:0] align_q;
  logic soft_rst_q;
  logic reg_rst;
  logic rise;
  logic fall;
  logic wr_en;
  logic [7:0] wr_data;

  // link pins come from another domain: two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      csn_s1_q <= 1'b1;
      csn_s2_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= link.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      csn_s1_q <= link.cs_n;
      csn_s2_q <= csn_s1_q;
      sdi_s1_q <= link.mosi;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  assign rise = sclk_s2_q & ~sclk_s3_q & ~csn_s2_q;
  assign fall = ~sclk_s2_q & sclk_s3_q & ~csn_s2_q;
  assign reg_rst = rst_i | soft_rst_q;
  assign hdr_addr = {sh_q[13:0], sdi_s2_q};
  assign wr_data = {sh_q[6:0], sdi_s2_q};
  assign wr_en = rise & (st_q == ST_DATA) & (bcnt_q == scr_pkg::BYTE_LAST) & ~rw_q;

  // next streaming address
  always_comb begin
    if (user_q[scr_pkg::USER_HOLD_BIT]) begin
      addr_d = addr_q;
    end else if (ifcfg_q[scr_pkg::IFCFG_ASCEND_BIT]) begin
      addr_d = addr_q + 15'h0001;
    end else begin
      addr_d = addr_q - 15'h0001;
    end
  end

  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      scr_pkg::ADDR_IFCFG: v = {1'b0, ifcfg_q[6:5], 1'b1, ifcfg_q[3:0]};
      scr_pkg::ADDR_MODE: v = mode_q;
      scr_pkg::ADDR_MAKER_LO: v = MAKER_CODE[7:0];
      scr_pkg::ADDR_MAKER_HI: v = MAKER_CODE[15:8];
      scr_pkg::ADDR_USER: v = user_q;
      scr_pkg::ADDR_ALIGN: v = align_q;
      scr_pkg::ADDR_POS0: v = align_edge_position_i[7:0];
      scr_pkg::ADDR_POS1: v = align_edge_position_i[15:8];
      scr_pkg::ADDR_POS2: v = align_edge_position_i[23:16];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // frame engine: 16-bit instruction, then bytes until chip select rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_HDR;
      bcnt_q <= 4'h0;
      sh_q <= 15'h0000;
      rw_q <= 1'b0;
      addr_q <= 15'h0000;
      tx_q <= 8'h00;
    end else if (csn_s2_q) begin
      st_q <= ST_HDR;
      bcnt_q <= 4'h0;
    end else if (rise) begin
      sh_q <= {sh_q[13:0], sdi_s2_q};
      bcnt_q <= bcnt_q + 4'h1;
      unique case (st_q)
        ST_HDR: begin
          if (bcnt_q == scr_pkg::INSTR_LAST) begin
            rw_q <= sh_q[14];
            addr_q <= hdr_addr;
            tx_q <= rd_byte(hdr_addr);
            bcnt_q <= 4'h0;
            st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bcnt_q == scr_pkg::BYTE_LAST) begin
            addr_q <= addr_d;
            tx_q <= rd_byte(addr_d);
            bcnt_q <= 4'h0;
          end
        end
      endcase
    end
  end

  // read data leaves only on the dedicated output, msb first, on falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q <= 1'b0;
    end else if (csn_s2_q) begin
      sdo_q <= 1'b0;
    end else if (fall && st_q == ST_DATA) begin
      sdo_q <= tx_q[3'h7 - bcnt_q[2:0]];
    end
  end

  assign link.miso = sdo_q;

  // one-cycle whole-chip reset; the trigger bit is never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_en & (addr_q == scr_pkg::ADDR_IFCFG) & wr_data[scr_pkg::IFCFG_RESET_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      ifcfg_q <= scr_pkg::IFCFG_RST;
      mode_q <= scr_pkg::MODE_RST;
      user_q <= scr_pkg::USER_RST;
      align_q <= scr_pkg::ALIGN_RST;
    end else if (wr_en) begin
      case (addr_q)
        scr_pkg::ADDR_IFCFG: ifcfg_q <= {1'b0, wr_data[6:5], 1'b1, wr_data[3:0]};
        scr_pkg::ADDR_MODE: mode_q <= wr_data;
        scr_pkg::ADDR_USER: user_q <= wr_data;
        scr_pkg::ADDR_ALIGN: align_q <= wr_data;
        default: ;
      endcase
    end
  end

  // controls towards the converter core
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      device_power_down_o <= 1'b0;
      align_receiver_on_o <= 1'b0;
      align_processor_on_o <= 1'b0;
      window_fine_scale_o <= 1'b0;
      align_delay_choice_o <= 4'h0;
    end else begin
      device_power_down_o <= (mode_q[1:0] == scr_pkg::MODE_POWER_DOWN);
      align_receiver_on_o <= align_q[scr_pkg::ALIGN_RECV_BIT];
      align_processor_on_o <= align_q[scr_pkg::ALIGN_PROC_BIT];
      window_fine_scale_o <= align_q[scr_pkg::ALIGN_ZOOM_BIT];
      align_delay_choice_o <= align_q[3:0];
    end
  end

  // events pass only with processor and receiver both on
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      align_event_o <= 1'b0;
    end else begin
      align_event_o <= align_event_i & align_q[scr_pkg::ALIGN_PROC_BIT] & align_q[scr_pkg::ALIGN_RECV_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_reset_o <= 1'b0;
    end else begin
      chip_reset_o <= soft_rst_q;
    end
  end

endmodule : scr_dev
`default_nettype wire

// ===== scr_host.sv
// Local design decision: the APB interface to the registers.
`default_nettype none
module scr_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  scr_link_if.hst link
);

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LOW = 5'b00010,
    HS_HIGH = 5'b00100,
    HS_TAIL = 5'b01000,
    HS_GUARD = 5'b10000
  } scr_host_st_t;

  scr_host_st_t st_q;
  logic [15:0] cmd_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic refused_q;
  logic recv_seen_q;
  logic rst_req_q;
  logic [23:0] sh_q;
  logic [7:0] rx_q;
  logic [4:0] bitn_q;
  logic [6:0] wait_q;
  logic sclk_q, csn_q, mosi_q;
  logic miso_s1_q, miso_s2_q;
  logic setup;
  logic acc;
  logic start;
  logic legal;
  logic [7:0] fixed;
  logic [31:0] rd_mux;
  logic mapped;
  logic tick;

  assign setup = psel_i & penable_i & ~pready_o;
  assign acc = psel_i & penable_i & pready_o;
  assign start = acc & pwrite_i & (paddr_i == scr_pkg::HOST_CMD_OFS) & pwdata_i[0] & (st_q == HS_IDLE);
  assign tick = (wait_q == 7'h00);

  // force reserved bits to their reset values
  always_comb begin
    fixed = wdata_q;
    case (cmd_q[14:0])
      scr_pkg::ADDR_IFCFG: fixed = (wdata_q & ~scr_pkg::IFCFG_RSV_MASK) | (scr_pkg::IFCFG_RST & scr_pkg::IFCFG_RSV_MASK);
      scr_pkg::ADDR_MODE: fixed = (wdata_q & ~scr_pkg::MODE_RSV_MASK) | (scr_pkg::MODE_RST & scr_pkg::MODE_RSV_MASK);
      scr_pkg::ADDR_USER: fixed = (wdata_q & ~scr_pkg::USER_RSV_MASK) | (scr_pkg::USER_RST & scr_pkg::USER_RSV_MASK);
      scr_pkg::ADDR_ALIGN: fixed = (wdata_q & ~scr_pkg::ALIGN_RSV_MASK) | (scr_pkg::ALIGN_RST & scr_pkg::ALIGN_RSV_MASK);
      default: fixed = wdata_q;
    endcase
  end

  // refuse reserved modes and processor enable ahead of receiver
  always_comb begin
    legal = 1'b1;
    if (!cmd_q[15] && cmd_q[14:0] == scr_pkg::ADDR_MODE && (wdata_q[1:0] == 2'h1 || wdata_q[1:0] == 2'h2)) begin
      legal = 1'b0;
    end
    if (!cmd_q[15] && cmd_q[14:0] == scr_pkg::ADDR_ALIGN && wdata_q[scr_pkg::ALIGN_PROC_BIT]
        && !wdata_q[scr_pkg::ALIGN_RECV_BIT] && !recv_seen_q) begin
      legal = 1'b0;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      scr_pkg::HOST_ADDR_OFS: rd_mux = {16'h0000, cmd_q};
      scr_pkg::HOST_WDATA_OFS: rd_mux = {24'h000000, wdata_q};
      scr_pkg::HOST_CMD_OFS: rd_mux = 32'h0000_0000;
      scr_pkg::HOST_STATUS_OFS: rd_mux = {16'h0000, rdata_q, 6'h00, refused_q, st_q != HS_IDLE};
      default: mapped = 1'b0;
    endcase
  end

  // apb slave: one wait cycle, then ready with registered data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (acc && pwrite_i && st_q == HS_IDLE) begin
      if (paddr_i == scr_pkg::HOST_ADDR_OFS) begin
        cmd_q <= pwdata_i[15:0];
      end
      if (paddr_i == scr_pkg::HOST_WDATA_OFS) begin
        wdata_q <= pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_q <= 1'b0;
      recv_seen_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else if (start) begin
      refused_q <= ~legal;
      if (legal) begin
        rst_req_q <= ~cmd_q[15] & (cmd_q[14:0] == scr_pkg::ADDR_IFCFG) & wdata_q[scr_pkg::IFCFG_RESET_BIT];
        if (!cmd_q[15] && cmd_q[14:0] == scr_pkg::ADDR_ALIGN) begin
          recv_seen_q <= wdata_q[scr_pkg::ALIGN_RECV_BIT];
        end else if (!cmd_q[15] && cmd_q[14:0] == scr_pkg::ADDR_IFCFG && wdata_q[scr_pkg::IFCFG_RESET_BIT]) begin
          recv_seen_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  // link engine: clock low half, high half, 24 bits per frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= HS_IDLE;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      mosi_q <= 1'b0;
      sh_q <= 24'h000000;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      bitn_q <= 5'h00;
      wait_q <= 7'h00;
    end else begin
      if (!tick) begin
        wait_q <= wait_q - 7'h01;
      end
      unique case (st_q)
        HS_IDLE: begin
          if (start && legal) begin
            sh_q <= {cmd_q, fixed};
            mosi_q <= cmd_q[15];
            csn_q <= 1'b0;
            bitn_q <= 5'h00;
            wait_q <= scr_pkg::SCLK_HALF_CYC - 7'h01;
            st_q <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[6:0], miso_s2_q};
            wait_q <= scr_pkg::SCLK_HALF_CYC - 7'h01;
            st_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            wait_q <= scr_pkg::SCLK_HALF_CYC - 7'h01;
            if (bitn_q == scr_pkg::FRAME_LAST) begin
              rdata_q <= rx_q;
              st_q <= HS_TAIL;
            end else begin
              sh_q <= {sh_q[22:0], 1'b0};
              mosi_q <= sh_q[22];
              bitn_q <= bitn_q + 5'h01;
              st_q <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          if (tick) begin
            csn_q <= 1'b1;
            mosi_q <= 1'b0;
            wait_q <= rst_req_q ? scr_pkg::RESET_WAIT_CYC - 7'h01 : scr_pkg::SCLK_HALF_CYC - 7'h01;
            st_q <= HS_GUARD;
          end
        end
        HS_GUARD: begin
          if (tick) begin
            st_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = csn_q;
  assign link.mosi = mosi_q;

endmodule : scr_host
`default_nettype wire

// ===== scr_link_chk.sv
`default_nettype none
module scr_link_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_q;
  logic soft_q;
  logic [4:0] rise_q;
  logic [8:0] low_q;
  logic [6:0] gap_q;
  logic [23:0] shf_q;
  always_ff @(posedge clk_i) sclk_q <= rst_i ? 1'b0 : sclk;
  always_ff @(posedge clk_i) rise_q <= (rst_i || cs_n) ? 5'h00 : rise_q + 5'(sclk && !sclk_q);
  always_ff @(posedge clk_i) low_q <= (rst_i || cs_n) ? 9'h000 : low_q + 9'h001;
  // idle time before each frame, saturating so reset counts as a long idle
  always_ff @(posedge clk_i) gap_q <= rst_i ? 7'h7F : (!cs_n ? 7'h00 : gap_q + 7'(gap_q != 7'h7F));
  always_ff @(posedge clk_i) if (sclk && !sclk_q) shf_q <= {shf_q[22:0], mosi};
  // last frame wrote the reset trigger at address zero
  always_ff @(posedge clk_i) soft_q <= rst_i ? 1'b0 : ($rose(cs_n) ? (shf_q[23:7] == 17'h00001) : soft_q);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  a_sclk_high_len: assert property ($rose(sclk) |-> ##10 $fell(sclk))
    else $error("link clock high phase wrong");
  a_sclk_low_len: assert property ($fell(sclk) |-> ##10 ($rose(sclk) || $rose(cs_n)))
    else $error("link clock low phase wrong");
  a_frame_lead_in: assert property ($fell(cs_n) |-> ##10 $rose(sclk))
    else $error("first clock rise misplaced");
  a_frame_cycle_len: assert property ($rose(cs_n) |-> low_q == 9'h1EA)
    else $error("frame length wrong");
  a_frame_bit_count: assert property ($rose(cs_n) |-> rise_q == 5'h18)
    else $error("frame bit count wrong");
  a_miso_instr_quiet: assert property (!cs_n && rise_q < 5'h10 |-> !miso)
    else $error("read line driven during instruction");
  a_miso_idle_low: assert property (cs_n && $past(cs_n, 8) |-> !miso)
    else $error("read line driven outside frame");
  a_mosi_hold_high: assert property (sclk |-> $stable(mosi))
    else $error("write line moved while clock high");
  a_miso_hold_high: assert property (sclk && rise_q < 5'h18 |-> $stable(miso))
    else $error("read line moved while clock high");
  a_frame_gap_min: assert property ($fell(cs_n) |-> gap_q >= scr_pkg::SCLK_HALF_CYC)
    else $error("frames too close");
  a_soft_reset_gap: assert property ($fell(cs_n) && soft_q |-> gap_q >= scr_pkg::RESET_WAIT_CYC)
    else $error("frame sent too soon after chip reset");
endmodule : scr_link_chk
`default_nettype wire

// ===== spi_config_sysref_ctrl_regs_tb.sv
`default_nettype none
module spi_config_sysref_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] RA [6] = '{scr_pkg::ADDR_IFCFG, scr_pkg::ADDR_MODE, scr_pkg::ADDR_MAKER_LO,
    scr_pkg::ADDR_MAKER_HI, scr_pkg::ADDR_USER, scr_pkg::ADDR_ALIGN};
  localparam logic [7:0] RV [6] = '{8'h30, 8'h00, scr_pkg::MAKER_CODE_DEF[7:0],
    scr_pkg::MAKER_CODE_DEF[15:8], 8'h00, 8'h80};
  localparam logic [14:0] RW [4] = '{scr_pkg::ADDR_IFCFG, scr_pkg::ADDR_MODE, scr_pkg::ADDR_USER, scr_pkg::ADDR_ALIGN};
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, ev, ev_out;
  logic chip_rst, pwr_dn, rx_on, proc_on, fine;
  logic [3:0] choice;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] edge_pos;
  int n_fail, checked, seed;
  int n_pulse = 0;
  logic asc, hold;
  scr_link_if link ();
  scr_host scr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
  scr_dev scr_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .align_edge_position_i(edge_pos),
    .align_event_i(ev), .chip_reset_o(chip_rst), .device_power_down_o(pwr_dn), .align_receiver_on_o(rx_on),
    .align_processor_on_o(proc_on), .window_fine_scale_o(fine), .align_delay_choice_o(choice),
    .align_event_o(ev_out));
  scr_link_chk scr_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (chip_rst === 1'b1) n_pulse++;
  task automatic conclude;
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_rd(input logic [14:0] a, input logic [7:0] w);
    case (a)
      scr_pkg::ADDR_IFCFG: exp_rd = (w & 8'h20) | 8'h10;
      scr_pkg::ADDR_MODE: exp_rd = w & 8'h03;
      scr_pkg::ADDR_USER: exp_rd = w & 8'h01;
      default: exp_rd = (w & 8'h7F) | 8'h80;
    endcase
  endfunction : exp_rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] w, output logic [31:0] st);
    logic [31:0] r;
    logic e;
    int i;
    apb(1'b1, scr_pkg::HOST_ADDR_OFS, {16'h0000, rd, a}, r, e);
    apb(1'b1, scr_pkg::HOST_WDATA_OFS, {24'h000000, w}, r, e);
    apb(1'b1, scr_pkg::HOST_CMD_OFS, 32'h00000001, r, e);
    st = 32'hFFFFFFFF;
    for (i = 0; i < 200 && st[scr_pkg::STAT_BUSY_BIT] !== 1'b0; i++) begin
      apb(1'b0, scr_pkg::HOST_STATUS_OFS, 32'h00000000, st, e);
    end
    if (st[scr_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      n_fail++;
      conclude();
    end
  endtask : xfer
  task automatic rdreg(input logic [14:0] a, output logic [7:0] b);
    logic [31:0] st;
    logic [14:0] nx;
    xfer(1'b1, a, 8'h00, st);
    b = st[scr_pkg::STAT_RDATA_LSB +: 8];
    // streaming address the device would use for a following byte
    nx = hold ? a : (asc ? a + 15'h0001 : a - 15'h0001);
    chk(32'(scr_dev_inst.addr_q), 32'(nx));
  endtask : rdreg
  task automatic chk_rst;
    logic [7:0] b;
    for (int i = 0; i < 6; i++) begin
      rdreg(RA[i], b);
      chk(32'(b), 32'(RV[i]));
    end
  endtask : chk_rst
  task automatic pulse_ev(input logic exp);
    @(posedge clk_i);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    @(negedge clk_i);
    chk(32'(ev_out), 32'(exp));
  endtask : pulse_ev
  initial begin
    logic [31:0] st, r;
    logic e;
    logic [7:0] w, b;
    logic [14:0] a;
    seed = 32'h6937;
    {n_fail, checked} = '0;
    {asc, hold} = 2'b10;
    {rst_i, psel, penable, pwrite, ev, paddr, pwdata, edge_pos} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({chip_rst, pwr_dn, rx_on, proc_on, fine, choice, ev_out}), 32'h0);
    chk_rst();
    xfer(1'b0, scr_pkg::ADDR_ALIGN, 8'hC0, st);
    chk(32'({st[scr_pkg::STAT_REFUSED_BIT], proc_on}), 32'h2);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b0, scr_pkg::ADDR_MODE, 8'(m), st);
      chk(32'({st[scr_pkg::STAT_REFUSED_BIT], pwr_dn}), {30'h0, m == 1 || m == 2, m == 3});
    end
    for (int i = 0; i < 12; i++) begin
      a = RW[i % 4];
      w = 8'($random(seed));
      if (a == scr_pkg::ADDR_IFCFG) w[7] = 1'b0;
      if (a == scr_pkg::ADDR_MODE) w[1] = w[0];
      if (a == scr_pkg::ADDR_ALIGN) w[5] = w[5] | w[6];
      xfer(1'b0, a, w, st);
      if (a == scr_pkg::ADDR_IFCFG) asc = w[5];
      if (a == scr_pkg::ADDR_USER) hold = w[0];
      if (a == scr_pkg::ADDR_ALIGN) chk(32'({proc_on, rx_on, fine, choice}), 32'(w[6:0]));
      if (a == scr_pkg::ADDR_MODE) chk(32'(pwr_dn), 32'(w[0]));
      rdreg(a, b);
      chk(32'(b), 32'(exp_rd(a, w)));
    end
    xfer(1'b0, scr_pkg::ADDR_MAKER_LO, 8'hFF, st);
    rdreg(scr_pkg::ADDR_MAKER_LO, b);
    chk(32'(b), 32'(scr_pkg::MAKER_CODE_DEF[7:0]));
    edge_pos <= 24'($random(seed));
    for (int i = 0; i < 3; i++) begin
      rdreg(scr_pkg::ADDR_POS0 + 15'(i), b);
      chk(32'(b), 32'(edge_pos[8 * i +: 8]));
    end
    xfer(1'b0, scr_pkg::ADDR_ALIGN, 8'hE0, st);
    pulse_ev(1'b1);
    xfer(1'b0, scr_pkg::ADDR_ALIGN, 8'hA0, st);
    pulse_ev(1'b0);
    apb(1'b0, 8'h10, 32'h00000000, r, e);
    chk({r[30:0], e}, 32'h1);
    xfer(1'b0, scr_pkg::ADDR_IFCFG, 8'h00, st);
    asc = 1'b0;
    rdreg(scr_pkg::ADDR_IFCFG, b);
    chk(32'(b), 32'h10);
    xfer(1'b0, scr_pkg::ADDR_USER, 8'h01, st);
    hold = 1'b1;
    rdreg(scr_pkg::ADDR_ALIGN, b);
    chk(32'(b), 32'hA0);
    xfer(1'b0, scr_pkg::ADDR_MODE, 8'h03, st);
    xfer(1'b0, scr_pkg::ADDR_ALIGN, 8'hFF, st);
    chk(32'(fine), 32'h1);
    xfer(1'b0, scr_pkg::ADDR_IFCFG, 8'h80, st);
    {asc, hold} = 2'b10;
    chk(32'(n_pulse), 32'h1);
    chk(32'({pwr_dn, proc_on, rx_on}), 32'h0);
    chk_rst();
    conclude();
  end
endmodule : spi_config_sysref_ctrl_regs_tb
`default_nettype wire
